// ### hw/jtap_pkg.sv
/*
 Shared constants, types and decode functions of the test access port.
 Assumes both ends and the bench run from one 125 MHz clock.
*/
package jtap_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int JTAP_CLK_NS = 8;
   localparam int JTAP_TCK_NS = 128;
   localparam int JTAP_TCK_HALF = JTAP_TCK_NS / (2 * JTAP_CLK_NS);

   // ------------------------------------------------------------
   // Instruction register
   // ------------------------------------------------------------
   localparam int JTAP_IR_W = 4;
   localparam logic [3:0] JTAP_IR_CAPTURE = 4'h1;
   localparam logic [3:0] JTAP_IR_EXTEST = 4'h0;
   localparam logic [3:0] JTAP_IR_IDCODE = 4'h1;
   localparam logic [3:0] JTAP_IR_SAMPLE = 4'h2;
   localparam logic [3:0] JTAP_IR_PROG = 4'h4;
   localparam logic [3:0] JTAP_IR_DBG_INT = 4'h8;
   localparam logic [3:0] JTAP_IR_DBG_BRK = 4'h9;
   localparam logic [3:0] JTAP_IR_BYPASS = 4'hF;

   // ------------------------------------------------------------
   // Data register lengths and host FIFO width and depth
   // ------------------------------------------------------------
   localparam int JTAP_DR_MAX = 32;
   localparam int JTAP_ID_LEN = 32;
   localparam int JTAP_BS_LEN = 8;
   localparam int JTAP_PRG_LEN = 16;
   localparam int JTAP_DBG_LEN = 16;
   localparam int JTAP_FIFO_W = 3;
   localparam int JTAP_FIFO_D = 4;

   typedef enum logic [3:0] {
      ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h3, ST_CAP_DR = 4'h2,
      ST_SH_DR = 4'h6, ST_EX1_DR = 4'h7, ST_UPD_DR = 4'h5, ST_PAU_DR = 4'h4,
      ST_EX2_DR = 4'hC, ST_SEL_IR = 4'hD, ST_CAP_IR = 4'hF, ST_SH_IR = 4'hE,
      ST_EX1_IR = 4'hA, ST_UPD_IR = 4'hB, ST_PAU_IR = 4'h9, ST_EX2_IR = 4'h8
   } jtap_state_t;

   typedef enum logic [2:0] {
      DR_BYP, DR_ID, DR_BS, DR_PRG, DR_INT, DR_BRK
   } jtap_dr_t;

   // Data register chosen by an instruction
   function automatic jtap_dr_t jtap_dr_sel(input logic [3:0] ir);
      jtap_dr_t s;
      s = DR_BYP;
      case (ir)
         JTAP_IR_EXTEST, JTAP_IR_SAMPLE: s = DR_BS;
         JTAP_IR_IDCODE: s = DR_ID;
         JTAP_IR_PROG: s = DR_PRG;
         JTAP_IR_DBG_INT: s = DR_INT;
         JTAP_IR_DBG_BRK: s = DR_BRK;
         default: s = DR_BYP;
      endcase
      return s;
   endfunction

   // Length of the chosen data register
   function automatic logic [5:0] jtap_dr_len(input jtap_dr_t s);
      logic [5:0] n;
      n = 6'h01;
      case (s)
         DR_ID: n = 6'(JTAP_ID_LEN);
         DR_BS: n = 6'(JTAP_BS_LEN);
         DR_PRG: n = 6'(JTAP_PRG_LEN);
         DR_INT, DR_BRK: n = 6'(JTAP_DBG_LEN);
         default: n = 6'h01;
      endcase
      return n;
   endfunction

endpackage

// ### hw/jtap_if.sv
/*
 Four-wire test port plus the open-drain system reset line.
 Assumes a pull-up on the data-out line and on the reset line.
*/
`timescale 1ns/1ps
interface jtap_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;
   logic sys_rst_o;
   logic sys_rst_oe;
   logic tdo_line;
   logic sys_rst_b_line;

   // Pull-ups resolve undriven lines
   assign tdo_line = tdo_oe ? tdo : 1'b1;
   assign sys_rst_b_line = sys_rst_oe ? sys_rst_o : 1'b1;

   modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
   modport host (output tck, output tms, output tdi, output sys_rst_o,
      output sys_rst_oe, input tdo_line, input sys_rst_b_line);
endinterface

// ### hw/jtap_fifo.sv
/*
 Small first-in first-out buffer with valid and ready on both sides.
 Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
module jtap_fifo #(
   parameter int W = 3,
   parameter int D = 4
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_in_valid,
   input wire logic [W-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [W-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic rdy;
   } jtap_fifo_st_t;

   jtap_fifo_st_t q;
   jtap_fifo_st_t d;
   logic push;
   logic pop;

   always_comb begin
      d = q;
      push = i_in_valid && q.rdy;
      pop = i_out_ready && (q.cnt != '0);
      if (push) begin
         d.mem[q.wp] = i_in_data;
         d.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
      end
      d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      d.rdy = (d.cnt != (AW + 1)'(D));
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '{rdy: 1'b1, default: '0};
      end else begin
         q <= d;
      end
   end

   assign o_in_ready = q.rdy;
   assign o_out_valid = (q.cnt != '0);
   assign o_out_data = q.mem[q.rp];
endmodule

// ### hw/jtap_dev.sv
/*
 Device end of the test access port: state machine, instruction
 register and data registers, sampled from the port on the system clock.
 Assumes TCK high and low phases of at least four clock cycles each,
 and TMS/TDI changed by the far end on the falling TCK edge.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Sixteen states stepped by TMS on rise
// - Power-on reset starts in Test-Logic-Reset
// - All shift registers move LSB first
// - Far end enters instruction shift 1,1,0,0
// - Four-bit instruction, top bit on exit
// - Instruction shift sends out fixed 0x01
// - Instruction takes effect only in Update-IR
// - Far end enters data shift 1,0,0
// - Data MSB shifts on the exit edge
// - Data shift sends captured parallel inputs
// - Latched data outputs change in Update-DR
// - Five TMS-high edges reach Test-Logic-Reset
// - Instruction picks the shift path between pins
// - ID, bypass, boundary, programming, debug chains
// - Exit and pause states do nothing
// - Update-IR may go straight to data select
// - Unprogrammed fuse: plain pins, controller reset
// - Enabled port: pulled-up inputs, TDO floats idle (only the TDO and reset lines have pull-ups here)
// - No test reset pin exists
// - Debugger watches and may pull system reset
module jtap_dev
   import jtap_pkg::*;
#(
   parameter logic [31:0] ID_VALUE = 32'h0000_0001
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   jtap_if.dev tap,
   input wire logic i_port_enable_fuse,
   input wire logic i_port_disable_bit,
   input wire logic [JTAP_BS_LEN-1:0] i_bs_in,
   input wire logic [JTAP_PRG_LEN-1:0] i_prg_in,
   input wire logic [JTAP_DBG_LEN-1:0] i_int_in,
   input wire logic [JTAP_DBG_LEN-1:0] i_brk_in,
   output logic [JTAP_BS_LEN-1:0] o_bs_out,
   output logic [JTAP_PRG_LEN-1:0] o_prg_out,
   output logic [JTAP_DBG_LEN-1:0] o_int_out,
   output logic [JTAP_DBG_LEN-1:0] o_brk_out,
   output logic [3:0] o_ir,
   output jtap_state_t o_state,
   output logic o_extest,
   output logic o_prg_run,
   output logic o_pins_gpio
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] tck_s;
      logic [1:0] tms_s;
      logic [1:0] tdi_s;
      jtap_state_t st;
      logic [3:0] ir_sh;
      logic [3:0] ir;
      logic [JTAP_DR_MAX-1:0] dr_sh;
      logic [JTAP_BS_LEN-1:0] bs_out;
      logic [JTAP_PRG_LEN-1:0] prg_out;
      logic [JTAP_DBG_LEN-1:0] int_out;
      logic [JTAP_DBG_LEN-1:0] brk_out;
      logic tdo;
      logic tdo_oe;
      logic extest;
      logic prg_run;
      logic gpio;
   } jtap_dev_st_t;

   localparam jtap_dev_st_t DEV_RST = '{
      st: ST_TLR, ir: JTAP_IR_IDCODE, gpio: 1'b1, default: '0};

   jtap_dev_st_t q;
   jtap_dev_st_t d;
   logic rise;
   logic fall;
   logic tms;
   logic tdi;
   logic en;
   jtap_dr_t sel;
   logic [5:0] len;

   // ------------------------------------------------------------
   // Next state of the controller
   // ------------------------------------------------------------
   function automatic jtap_state_t jtap_next(input jtap_state_t s, input logic m);
      jtap_state_t n;
      n = s;
      unique case (s)
         ST_TLR: n = m ? ST_TLR : ST_RTI;
         ST_RTI: n = m ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: n = m ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: n = m ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: n = m ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: n = m ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: n = m ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: n = m ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: n = m ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: n = m ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: n = m ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: n = m ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: n = m ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: n = m ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: n = m ? ST_SEL_DR : ST_RTI;
      endcase
      return n;
   endfunction

   // ------------------------------------------------------------
   // Combinational update
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      rise = q.tck_s[1] && !q.tck_s[2];
      fall = !q.tck_s[1] && q.tck_s[2];
      tms = q.tms_s[1];
      tdi = q.tdi_s[1];
      en = i_port_enable_fuse && !i_port_disable_bit;
      sel = jtap_dr_sel(q.ir);
      len = jtap_dr_len(sel);

      if (rise) begin
         // five high edges end in reset
         d.st = jtap_next(q.st, tms);
         case (q.st)
            ST_TLR: d.ir = JTAP_IR_IDCODE;
            ST_CAP_IR: d.ir_sh = JTAP_IR_CAPTURE;
            ST_SH_IR: d.ir_sh = {tdi, q.ir_sh[3:1]};
            ST_UPD_IR: d.ir = q.ir_sh;
            ST_CAP_DR: begin
               d.dr_sh = '0;
               case (sel)
                  DR_ID: d.dr_sh = ID_VALUE;
                  DR_BS: d.dr_sh[JTAP_BS_LEN-1:0] = i_bs_in;
                  DR_PRG: d.dr_sh[JTAP_PRG_LEN-1:0] = i_prg_in;
                  DR_INT: d.dr_sh[JTAP_DBG_LEN-1:0] = i_int_in;
                  DR_BRK: d.dr_sh[JTAP_DBG_LEN-1:0] = i_brk_in;
                  default: d.dr_sh = '0;
               endcase
            end
            ST_SH_DR: begin
               // Bits above the chosen length stay zero from capture
               d.dr_sh = {1'b0, q.dr_sh[JTAP_DR_MAX-1:1]};
               d.dr_sh[5'(len - 6'h01)] = tdi;
            end
            ST_UPD_DR: begin
               case (sel)
                  DR_BS: d.bs_out = q.dr_sh[JTAP_BS_LEN-1:0];
                  DR_PRG: d.prg_out = q.dr_sh[JTAP_PRG_LEN-1:0];
                  DR_INT: d.int_out = q.dr_sh[JTAP_DBG_LEN-1:0];
                  DR_BRK: d.brk_out = q.dr_sh[JTAP_DBG_LEN-1:0];
                  default: d.bs_out = q.bs_out;
               endcase
            end
            default: d.st = jtap_next(q.st, tms);
         endcase
         if (d.st == ST_TLR) begin
            d.ir = JTAP_IR_IDCODE;
         end
      end

      if (fall) begin
         d.tdo_oe = (q.st == ST_SH_IR) || (q.st == ST_SH_DR);
         d.tdo = (q.st == ST_SH_IR) ? q.ir_sh[0] : q.dr_sh[0];
      end

      d.extest = (d.ir == JTAP_IR_EXTEST);
      d.prg_run = (d.st == ST_RTI) && (d.ir == JTAP_IR_PROG);
      d.gpio = 1'b0;

      if (!en) begin
         d = DEV_RST;
      end
      d.tck_s = {q.tck_s[1:0], tap.tck};
      d.tms_s = {q.tms_s[0], tap.tms};
      d.tdi_s = {q.tdi_s[0], tap.tdi};
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // power-on state
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= DEV_RST;
      end else begin
         q <= d;
      end
   end

   assign tap.tdo = q.tdo;
   assign tap.tdo_oe = q.tdo_oe;
   assign o_bs_out = q.bs_out;
   assign o_prg_out = q.prg_out;
   assign o_int_out = q.int_out;
   assign o_brk_out = q.brk_out;
   assign o_ir = q.ir;
   assign o_state = q.st;
   assign o_extest = q.extest;
   assign o_prg_run = q.prg_run;
   assign o_pins_gpio = q.gpio;
endmodule

// ### hw/jtap_host.sv
/*
 Far end of the test access port: makes TCK by division, plays out
 queued TMS/TDI bits and returns the TDO bits asked for.
 Assumes a device that drives TDO from the falling TCK edge.
*/
`timescale 1ns/1ps
module jtap_host
   import jtap_pkg::*;
#(
   parameter int HALF = JTAP_TCK_HALF,
   parameter int FW = JTAP_FIFO_W,
   parameter int FD = JTAP_FIFO_D
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   jtap_if.host tap,
   input wire logic i_bit_valid,
   input wire logic i_bit_tms,
   input wire logic i_bit_tdi,
   input wire logic i_bit_cap,
   output logic o_bit_ready,
   output logic o_tdo_valid,
   output logic o_tdo_bit,
   input wire logic i_pull_sys_rst,
   output logic o_sys_rst_seen
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic cap;
      logic busy;
      logic [7:0] cnt;
      logic [1:0] tdo_s;
      logic [1:0] rst_s;
      logic rst_seen;
      logic rst_oe;
      logic vld;
      logic bit_o;
   } jtap_host_st_t;

   jtap_host_st_t q;
   jtap_host_st_t d;
   logic f_valid;
   logic [FW-1:0] f_data;

   jtap_fifo #(.W(FW), .D(FD)) u_fifo (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_in_valid(i_bit_valid),
      .i_in_data({i_bit_cap, i_bit_tdi, i_bit_tms}),
      .o_in_ready(o_bit_ready),
      .o_out_valid(f_valid),
      .o_out_data(f_data),
      .i_out_ready(!q.busy)
   );

   always_comb begin
      d = q;
      d.vld = 1'b0;
      d.tdo_s = {q.tdo_s[0], tap.tdo_line};
      d.rst_s = {q.rst_s[0], tap.sys_rst_b_line};
      d.rst_seen = !q.rst_s[1];
      d.rst_oe = i_pull_sys_rst;
      if (!q.busy) begin
         if (f_valid) begin
            d.busy = 1'b1;
            d.tms = f_data[0];
            d.tdi = f_data[1];
            d.cap = f_data[2];
            d.cnt = '0;
         end
      end else if (q.cnt == 8'(HALF - 1)) begin
         d.cnt = '0;
         if (!q.tck) begin
            d.tck = 1'b1;
         end else begin
            // Late sample: TDO stands fall to fall, sync delay covered
            d.tck = 1'b0;
            d.busy = 1'b0;
            d.vld = q.cap;
            d.bit_o = q.tdo_s[1];
         end
      end else begin
         d.cnt = q.cnt + 8'h01;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '{tms: 1'b1, rst_s: 2'h3, default: '0};
      end else begin
         q <= d;
      end
   end

   assign tap.tck = q.tck;
   assign tap.tms = q.tms;
   assign tap.tdi = q.tdi;
   assign tap.sys_rst_o = 1'b0;
   assign tap.sys_rst_oe = q.rst_oe;
   assign o_tdo_valid = q.vld;
   assign o_tdo_bit = q.bit_o;
   assign o_sys_rst_seen = q.rst_seen;
endmodule

// ### tb/jtap_props.sv
/*
 Wire checks between the host and device ends of the test port.
 Assumes a host TCK half period of at least four clocks.
*/
`timescale 1ns/1ps
module jtap_props (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic sys_rst_o,
   input wire logic sys_rst_oe,
   input wire logic tdo_line,
   input wire logic sys_rst_b_line
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);
   // ------------------------------------------------------------
   // TMS seen at TCK rises
   // ------------------------------------------------------------
   logic tck_q;
   logic last_tms_q;
   logic [2:0] hi_cnt_q;
   logic [2:0] hi_cnt_d;
   always_comb begin
      hi_cnt_d = hi_cnt_q;
      if (tck && !tck_q) begin
         hi_cnt_d = (tms && hi_cnt_q != 3'h5) ? hi_cnt_q + 3'h1 : {3{tms}} & hi_cnt_q;
      end
   end
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tck_q <= 1'b0;
         last_tms_q <= 1'b1;
         hi_cnt_q <= 3'h0;
      end else begin
         tck_q <= tck;
         hi_cnt_q <= hi_cnt_d;
         if (tck && !tck_q) begin
            last_tms_q <= tms;
         end
      end
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   chk_tck_high_min: assert property ($rose(tck) |-> tck [*4])
      else $error("TCK high phase too short");
   chk_tck_low_min: assert property ($fell(tck) |-> (!tck) [*4])
      else $error("TCK low phase too short");
   chk_tms_tdi_hold: assert property (tck && $past(tck) |-> $stable({tms, tdi}))
      else $error("TMS or TDI moved while TCK high");
   chk_tdo_hold_high: assert property (tck |-> $stable(tdo) && $stable(tdo_oe))
      else $error("TDO moved while TCK high");
   chk_tdo_line_pullup: assert property (!tdo_oe |-> tdo_line)
      else $error("Undriven TDO line not high");
   chk_oe_shift_only: assert property ($changed(tdo_oe) |-> tdo_oe != last_tms_q)
      else $error("TDO drive changed without shift entry or exit");
   chk_five_high_reset: assert property ($fell(tck) && hi_cnt_q == 3'h5 |-> ##5 !tdo_oe)
      else $error("TDO driven after five TMS-high rises");
   chk_sys_rst_od: assert property (sys_rst_oe |-> !sys_rst_o && !sys_rst_b_line)
      else $error("System reset line driven high");
   cover property ($rose(tdo_oe));
   cover property ($fell(tck) && hi_cnt_q == 3'h5);
   cover property ($rose(sys_rst_oe));
endmodule

// ### tb/tb_top.sv
/*
 Bench: host end drives the device end across the port interface.
 Assumes host and device share i_mclk and a four-word host FIFO.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
$display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
module tb_top
   import jtap_pkg::*;
;
   localparam int HALF = 4;
   // Arbitrary identification value
   localparam logic [31:0] ID = 32'h5A3C_0F01;
   localparam logic [31:0] PAT = 32'h0009_C35A;
   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   logic fuse = 1'b1, dis = 1'b0, pull = 1'b0, saw_full = 1'b0;
   logic bit_valid = 1'b0, bit_tms = 1'b1, bit_tdi = 1'b0, bit_cap = 1'b1;
   logic bit_ready, tdo_valid, tdo_bit, rst_seen, extest, prg_run, gpio;
   logic [7:0] bs_in = 8'h96;
   logic [15:0] prg_in = 16'h1E2D, int_in = 16'h3C4B, brk_in = 16'h5A69;
   logic [7:0] bs_out;
   logic [15:0] prg_out, int_out, brk_out;
   logic [3:0] ir_out;
   logic [3:0] codes [8] = '{4'h2, 4'h0, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB, 4'hF};
   jtap_state_t state;
   logic [31:0] g, junk;
   logic tdo_q[$];
   int n_errors = 0;
   int cmp_count = 0;
   jtap_if bus();
   always #4 i_mclk = ~i_mclk;
   jtap_dev #(.ID_VALUE(ID)) jtap_dev_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .tap(bus),
      .i_port_enable_fuse(fuse), .i_port_disable_bit(dis), .i_bs_in(bs_in),
      .i_prg_in(prg_in), .i_int_in(int_in), .i_brk_in(brk_in), .o_bs_out(bs_out),
      .o_prg_out(prg_out), .o_int_out(int_out), .o_brk_out(brk_out), .o_ir(ir_out),
      .o_state(state), .o_extest(extest), .o_prg_run(prg_run), .o_pins_gpio(gpio));
   jtap_host #(.HALF(HALF)) jtap_host_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .tap(bus),
      .i_bit_valid(bit_valid), .i_bit_tms(bit_tms), .i_bit_tdi(bit_tdi), .i_bit_cap(bit_cap),
      .o_bit_ready(bit_ready), .o_tdo_valid(tdo_valid), .o_tdo_bit(tdo_bit),
      .i_pull_sys_rst(pull), .o_sys_rst_seen(rst_seen));
   jtap_props jtap_props_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .tck(bus.tck), .tms(bus.tms),
      .tdi(bus.tdi), .tdo(bus.tdo), .tdo_oe(bus.tdo_oe), .sys_rst_o(bus.sys_rst_o),
      .sys_rst_oe(bus.sys_rst_oe), .tdo_line(bus.tdo_line),
      .sys_rst_b_line(bus.sys_rst_b_line));
   always @(posedge i_mclk) begin
      if (tdo_valid === 1'b1) tdo_q.push_back(tdo_bit);
      if (bit_valid && bit_ready === 1'b0) saw_full <= 1'b1;
   end
   // ------------------------------------------------------------
   // Expected lengths and captures
   // ------------------------------------------------------------
   function automatic int tb_len(input logic [3:0] c);
      case (c)
         4'h0, 4'h2: return 8;
         4'h4, 4'h8, 4'h9: return 16;
         default: return 1;
      endcase
   endfunction
   function automatic logic [31:0] tb_cap(input logic [3:0] c);
      case (c)
         4'h0, 4'h2: return {24'h0, bs_in};
         4'h4: return {16'h0, prg_in};
         4'h8: return {16'h0, int_in};
         4'h9: return {16'h0, brk_in};
         default: return 32'h0;
      endcase
   endfunction
   // ------------------------------------------------------------
   // Port access tasks
   // ------------------------------------------------------------
   task automatic xfer(input logic [31:0] mv, input logic [31:0] dv, input int n,
      output logic [31:0] q);
      q = 32'h0;
      tdo_q.delete();
      for (int k = 0; k < n; k++) begin
         @(negedge i_mclk);
         bit_valid = 1'b1;
         bit_tms = mv[k];
         bit_tdi = dv[k];
         while (bit_ready !== 1'b1) @(negedge i_mclk);
         @(posedge i_mclk);
      end
      @(negedge i_mclk);
      bit_valid = 1'b0;
      for (int k = 0; k < 2000 && tdo_q.size() < n; k++) @(negedge i_mclk);
      `CHK("tdo count", n, tdo_q.size())
      foreach (tdo_q[k]) q[k] = tdo_q[k];
   endtask
   task automatic ir(input logic [3:0] code);
      logic [3:0] old;
      old = ir_out;
      xfer(32'h3, 32'h0, 4, junk);
      xfer(32'h8, {28'h0, code}, 4, g);
      `CHK("ir capture", 4'h1, g[3:0])
      `CHK("ir held", old, ir_out)
      xfer(32'h1, 32'h0, 2, junk);
      `CHK("ir", code, ir_out)
   endtask
   task automatic dr(input int n, input logic [31:0] d, output logic [31:0] q);
      logic [55:0] snap;
      snap = {bs_out, prg_out, int_out, brk_out};
      xfer(32'h1, 32'h0, 3, junk);
      xfer(32'h1 << (n - 1), d, n, q);
      xfer(32'h2, 32'h0, 2, junk);
      `CHK("pause", snap, {bs_out, prg_out, int_out, brk_out})
      `CHK("state", ST_EX2_DR, state)
      xfer(32'h1, 32'h0, 2, junk);
   endtask
   task end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge i_mclk);
      n_errors++;
      $display("watchdog expired");
      end_of_test();
   end
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      logic [3:0] c;
      int n;
      logic [31:0] m, e, x;
      repeat (6) @(negedge i_mclk);
      `CHK("gpio in reset", 1'b1, gpio)
      i_rst_b = 1'b1;
      @(negedge i_mclk);
      `CHK("state", ST_TLR, state)
      `CHK("ir", JTAP_IR_IDCODE, ir_out)
      `CHK("gpio", 1'b0, gpio)
      `CHK("tdo idle", 1'b1, bus.tdo_line)
      $display("test reset done");
      xfer(32'h0, 32'h0, 1, junk);
      `CHK("state", ST_RTI, state)
      dr(32, 32'h0, g);
      `CHK("idcode", ID, g)
      $display("test idcode done");
      foreach (codes[i]) begin
         c = codes[i];
         n = tb_len(c);
         m = (32'h1 << n) - 32'h1;
         e = (PAT >> 4) & m;
         ir(c);
         `CHK("extest", c == 4'h0, extest)
         x = ((tb_cap(c) & m) | (PAT << n)) & ((m << 4) | 32'hF);
         dr(n + 4, PAT, g);
         `CHK("capture", x, g)
         case (c)
            4'h0: `CHK("bs out", e[7:0], bs_out)
            4'h4: `CHK("prg out", e[15:0], prg_out)
            4'h8: `CHK("int out", e[15:0], int_out)
            4'h9: `CHK("brk out", e[15:0], brk_out)
            default: ;
         endcase
         `CHK("prg run", c == 4'h4, prg_run)
      end
      $display("test instructions done");
      xfer(32'h3, 32'h0, 4, junk);
      xfer(32'h8, 32'h1, 4, junk);
      xfer(32'h3, 32'h0, 4, junk);
      xfer(32'h8000_0000, 32'h0, 32, g);
      `CHK("idcode direct", ID, g)
      xfer(32'h1, 32'h0, 2, junk);
      $display("test direct done");
      ir(4'hF);
      xfer(32'h1, 32'h0, 3, junk);
      repeat (4) @(negedge i_mclk);
      `CHK("tdo drive", 1'b1, bus.tdo_oe)
      xfer(32'h1F, 32'h0, 5, junk);
      `CHK("state", ST_TLR, state)
      `CHK("ir", JTAP_IR_IDCODE, ir_out)
      xfer(32'h0, 32'h0, 1, junk);
      $display("test five high done");
      for (int j = 0; j < 2; j++) begin
         ir(4'hF);
         @(negedge i_mclk);
         fuse = j[0];
         dis = j[0];
         repeat (4) @(negedge i_mclk);
         `CHK("gpio", 1'b1, gpio)
         `CHK("state", ST_TLR, state)
         `CHK("ir", JTAP_IR_IDCODE, ir_out)
         fuse = 1'b1;
         dis = 1'b0;
         xfer(32'h0, 32'h0, 1, junk);
      end
      $display("test disable done");
      pull = 1'b1;
      repeat (4) @(negedge i_mclk);
      `CHK("reset line", 1'b0, bus.sys_rst_b_line)
      `CHK("reset seen", 1'b1, rst_seen)
      pull = 1'b0;
      repeat (4) @(negedge i_mclk);
      `CHK("reset seen", 1'b0, rst_seen)
      `CHK("fifo refused", 1'b1, saw_full)
      $display("test system reset done");
      end_of_test();
   end
endmodule
